// File: bench/mdu_unit_bench.sv
`timescale 1ns/1ps
module mdu_unit_bench
    import mdu_pkg::*;
;
    logic clk;
    logic nrst;
    mdu_req_s req;
    logic [15:0] rdata;
    logic divide_done_irq;
    int miscompares;
    int compares;
    int cyc = 0;

    mdu_unit i_mdu_unit
    (
        .clk(clk),
        .nrst(nrst),
        .req(req),
        .rdata(rdata),
        .divide_done_irq(divide_done_irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) cyc <= cyc + 1;

    task automatic complete_run;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    task automatic rdc(input logic [19:0] a, input logic [15:0] exp);
        @(posedge clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic t_reset;
        rdc(MDU_ADDR_CTRL, 16'h0000);
        rdc(MDU_ADDR_A_LOW, 16'h0000);
        rdc(MDU_ADDR_A_HIGH, 16'h0000);
        rdc(MDU_ADDR_B_LOW, 16'h0000);
        rdc(MDU_ADDR_B_HIGH, 16'h0000);
        rdc(MDU_ADDR_REM_LOW, 16'h0000);
        rdc(MDU_ADDR_REM_HIGH, 16'h0000);
        rdc(20'hF00E0, MDU_UNMAPPED_READ);
    endtask

    task automatic t_mul;
        wr(MDU_ADDR_CTRL, 16'h007F);
        rdc(MDU_ADDR_CTRL, 16'h0000);
        wr(MDU_ADDR_A_HIGH, 16'h0003);
        wr(MDU_ADDR_A_LOW, 16'h0002);
        rdc(MDU_ADDR_B_LOW, 16'h0006);
        rdc(MDU_ADDR_B_HIGH, 16'h0000);
        wr(MDU_ADDR_A_LOW, 16'hFFFF);
        wr(MDU_ADDR_A_HIGH, 16'hFFFF);
        rdc(MDU_ADDR_B_HIGH, 16'hFFFE);
        rdc(MDU_ADDR_B_LOW, 16'h0001);
        // A lone half must leave the last product in place.
        wr(MDU_ADDR_A_LOW, 16'h0002);
        rdc(MDU_ADDR_B_LOW, 16'h0001);
        wr(MDU_ADDR_REM_LOW, 16'h5A5A);
        rdc(MDU_ADDR_REM_LOW, 16'h0000);
    endtask

    task automatic t_div(input logic [31:0] n, input logic [31:0] d,
        input logic [31:0] q, input logic [31:0] r, input bit poke);
        int s;
        wr(MDU_ADDR_CTRL, 16'h0080);
        wr(MDU_ADDR_B_LOW, d[15:0]);
        wr(MDU_ADDR_A_HIGH, n[31:16]);
        wr(MDU_ADDR_B_HIGH, d[31:16]);
        wr(MDU_ADDR_A_LOW, n[15:0]);
        wr(MDU_ADDR_CTRL, 16'h0081);
        #1;
        s = cyc;
        if (poke)
        begin
            wr(MDU_ADDR_CTRL, 16'h0080);
            rdc(MDU_ADDR_CTRL, 16'h0081);
        end
        repeat (20)
        begin
            @(posedge clk);
            #1;
            if (divide_done_irq === 1'b1)
                break;
        end
        chk(16'(cyc - s), 16'h0010);
        @(posedge clk);
        #1;
        chk({15'h0000, divide_done_irq}, 16'h0000);
        rdc(MDU_ADDR_CTRL, 16'h0080);
        rdc(MDU_ADDR_A_LOW, q[15:0]);
        rdc(MDU_ADDR_A_HIGH, q[31:16]);
        rdc(MDU_ADDR_REM_LOW, r[15:0]);
        rdc(MDU_ADDR_REM_HIGH, r[31:16]);
    endtask

    task automatic t_back;
        wr(MDU_ADDR_CTRL, 16'h0000);
        wr(MDU_ADDR_A_LOW, 16'h1234);
        wr(MDU_ADDR_A_HIGH, 16'h0010);
        rdc(MDU_ADDR_B_LOW, 16'h2340);
        rdc(MDU_ADDR_B_HIGH, 16'h0001);
        rdc(MDU_ADDR_REM_LOW, 16'h0002);
    endtask

    // A second reset after real work, so that the operand registers and the
    // low remainder read back have something to lose.
    task automatic t_rerun;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
    endtask

    initial
    begin
        req = '0;
        nrst = 1'b0;
        miscompares = 0;
        compares = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_mul;
        t_div(32'h00000023, 32'h00000006, 32'h00000005, 32'h00000005, 1'b1);
        t_div(32'hFFFFFFFF, 32'h00010000, 32'h0000FFFF, 32'h0000FFFF, 1'b0);
        t_div(32'h80000000, 32'h00000003, 32'h2AAAAAAA, 32'h00000002, 1'b0);
        t_back;
        t_rerun;
        complete_run;
    end

    // The whole sequence needs well under a thousand clocks, so this span
    // only trips on a hang.
    initial
    begin
        #100000;
        miscompares++;
        complete_run;
    end
endmodule // mdu_unit_bench

// File: verilog/mdu_pkg.sv
package mdu_pkg;

    // Register addresses on the system register port.
    localparam logic [19:0] MDU_ADDR_CTRL = 20'hF00E8;
    localparam logic [19:0] MDU_ADDR_A_LOW = 20'hF00F0;
    localparam logic [19:0] MDU_ADDR_A_HIGH = 20'hF00F2;
    localparam logic [19:0] MDU_ADDR_B_LOW = 20'hF00F4;
    localparam logic [19:0] MDU_ADDR_B_HIGH = 20'hF00F6;
    localparam logic [19:0] MDU_ADDR_REM_LOW = 20'hF00F8;
    localparam logic [19:0] MDU_ADDR_REM_HIGH = 20'hF00FA;

    // Field positions in arith_control.
    localparam int MDU_SELECT_BIT = 7;
    localparam int MDU_GO_BIT = 0;

    // Values after reset, and the value read from an unmapped address.
    localparam logic [7:0] MDU_CTRL_RESET = 8'h00;
    localparam logic [15:0] MDU_DATA_RESET = 16'h0000;
    localparam logic [15:0] MDU_UNMAPPED_READ = 16'h0000;

    // A division retires two quotient bits per clock.
    localparam int MDU_DIV_CLOCKS = 16;
    localparam logic [3:0] MDU_DIV_LAST = 4'(MDU_DIV_CLOCKS - 1);
    localparam logic [3:0] MDU_CNT_RESET = 4'h0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [19:0] addr;
        logic [15:0] wdata;
    } mdu_req_s;

    typedef enum logic {
        MDU_IDLE = 1'b0,
        MDU_DIV = 1'b1
    } mdu_state_e;

endpackage

// File: verilog/mdu_unit.sv
`timescale 1ns/1ps
module mdu_unit
    import mdu_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire mdu_req_s req,
    output logic [15:0] rdata,
    output logic divide_done_irq
);

    logic [15:0] operand_a_low, operand_a_high;
    logic [15:0] operand_b_low, operand_b_high;
    logic [15:0] remainder_low, remainder_high;
    logic divide_select, hi_written, lo_written, mul_pend;
    mdu_state_e state;
    logic [3:0] cnt;

    logic [15:0] next_operand_a_low, next_operand_a_high;
    logic [15:0] next_operand_b_low, next_operand_b_high;
    logic [15:0] next_remainder_low, next_remainder_high;
    logic next_divide_select, next_hi_written, next_lo_written;
    logic next_mul_pend, next_divide_done_irq;
    mdu_state_e next_state;
    logic [3:0] next_cnt;
    logic [15:0] next_rdata;

    logic divide_go;
    logic [31:0] product;
    logic [63:0] step_one, step_two;

    // One restoring step on {remainder, quotient}; operands are unsigned.
    // A zero divisor is not trapped: every step subtracts, so the quotient
    // ends all ones and the remainder keeps the dividend.
    function automatic logic [63:0] div_step(input logic [63:0] rq,
                                             input logic [31:0] d);
        logic [32:0] r2;
        logic [31:0] q2;
        r2 = {rq[63:32], rq[31]};
        q2 = {rq[30:0], 1'b0};
        if (r2 >= {1'b0, d})
        begin
            r2 = r2 - {1'b0, d};
            q2[0] = 1'b1;
        end
        return {r2[31:0], q2};
    endfunction

    assign divide_go = (state == MDU_DIV);
    assign product = operand_a_high * operand_a_low;
    assign step_one = div_step({remainder_high, remainder_low,
                                operand_a_high, operand_a_low},
                               {operand_b_high, operand_b_low});
    assign step_two = div_step(step_one,
                               {operand_b_high, operand_b_low});

    always_comb
    begin
        next_operand_a_low = operand_a_low;
        next_operand_a_high = operand_a_high;
        next_operand_b_low = operand_b_low;
        next_operand_b_high = operand_b_high;
        next_remainder_low = remainder_low;
        next_remainder_high = remainder_high;
        next_divide_select = divide_select;
        next_hi_written = hi_written;
        next_lo_written = lo_written;
        next_mul_pend = 1'b0;
        next_divide_done_irq = 1'b0;
        next_state = state;
        next_cnt = cnt;
        next_rdata = rdata;

        if (req.wr)
        begin
            case (req.addr)
                MDU_ADDR_CTRL:
                begin
                    next_divide_select = req.wdata[MDU_SELECT_BIT];
                    // Go is set only alongside divide mode; a busy unit
                    // keeps go whatever is written to it.
                    if (!divide_go && req.wdata[MDU_SELECT_BIT]
                        && req.wdata[MDU_GO_BIT])
                    begin
                        next_state = MDU_DIV;
                        next_cnt = MDU_CNT_RESET;
                        next_remainder_low = MDU_DATA_RESET;
                        next_remainder_high = MDU_DATA_RESET;
                    end
                end
                MDU_ADDR_A_LOW:
                begin
                    next_operand_a_low = req.wdata;
                    next_lo_written = !divide_select;
                end
                MDU_ADDR_A_HIGH:
                begin
                    next_operand_a_high = req.wdata;
                    next_hi_written = !divide_select;
                end
                MDU_ADDR_B_LOW: next_operand_b_low = req.wdata;
                MDU_ADDR_B_HIGH: next_operand_b_high = req.wdata;
                default: ;
            endcase
        end

        // Both halves seen: fire once and demand two fresh writes. Halves
        // written in divide mode clear their flag, so loading a dividend
        // never launches a stray multiply.
        if (next_hi_written && next_lo_written)
        begin
            next_mul_pend = 1'b1;
            next_hi_written = 1'b0;
            next_lo_written = 1'b0;
        end

        // The product overrides a same-cycle software write to pair B.
        if (mul_pend)
        begin
            next_operand_b_low = product[15:0];
            next_operand_b_high = product[31:16];
        end

        // Division steps take priority over software writes to pair A.
        if (divide_go)
        begin
            {next_remainder_high, next_remainder_low} =
                step_two[63:32];
            {next_operand_a_high, next_operand_a_low} =
                step_two[31:0];
            next_cnt = cnt + 4'h1;
            if (cnt == MDU_DIV_LAST)
            begin
                next_state = MDU_IDLE;
                next_divide_done_irq = 1'b1;
            end
        end

        if (req.rd)
        begin
            case (req.addr)
                MDU_ADDR_CTRL:
                    next_rdata = {8'h00, divide_select, 6'h00,
                                  divide_go};
                MDU_ADDR_A_LOW: next_rdata = operand_a_low;
                MDU_ADDR_A_HIGH: next_rdata = operand_a_high;
                MDU_ADDR_B_LOW: next_rdata = operand_b_low;
                MDU_ADDR_B_HIGH: next_rdata = operand_b_high;
                MDU_ADDR_REM_LOW: next_rdata = remainder_low;
                MDU_ADDR_REM_HIGH: next_rdata = remainder_high;
                default: next_rdata = MDU_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            operand_a_low <= MDU_DATA_RESET;
            operand_a_high <= MDU_DATA_RESET;
            operand_b_low <= MDU_DATA_RESET;
            operand_b_high <= MDU_DATA_RESET;
            remainder_low <= MDU_DATA_RESET;
            remainder_high <= MDU_DATA_RESET;
            divide_select <= MDU_CTRL_RESET[MDU_SELECT_BIT];
            state <= MDU_IDLE;
            hi_written <= 1'b0;
            lo_written <= 1'b0;
            mul_pend <= 1'b0;
            cnt <= MDU_CNT_RESET;
            divide_done_irq <= 1'b0;
            rdata <= MDU_DATA_RESET;
        end
        else
        begin
            operand_a_low <= next_operand_a_low;
            operand_a_high <= next_operand_a_high;
            operand_b_low <= next_operand_b_low;
            operand_b_high <= next_operand_b_high;
            remainder_low <= next_remainder_low;
            remainder_high <= next_remainder_high;
            divide_select <= next_divide_select;
            state <= next_state;
            hi_written <= next_hi_written;
            lo_written <= next_lo_written;
            mul_pend <= next_mul_pend;
            cnt <= next_cnt;
            divide_done_irq <= next_divide_done_irq;
            rdata <= next_rdata;
        end
    end

    // Dividend and divisor captured at go, only for the checks below.
    logic [31:0] chk_dividend, chk_divisor;
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            chk_dividend <= 32'h0000_0000;
            chk_divisor <= 32'h0000_0000;
        end
        else if (!divide_go && next_state == MDU_DIV)
        begin
            chk_dividend <= {next_operand_a_high, next_operand_a_low};
            chk_divisor <= {next_operand_b_high, next_operand_b_low};
        end
    end

    default clocking cb @(posedge clk); endclocking

    reset_clears_a: assert property (
        !nrst |=> (remainder_low == 16'h0000 && remainder_high == 16'h0000
                   && operand_a_low == 16'h0000 && operand_b_high == 16'h0000
                   && !divide_select && !divide_go))
        else $error("reset did not clear the unit");

    div_length_a: assert property (disable iff (!nrst)
        $rose(divide_go) |-> ##16 (!divide_go && divide_done_irq))
        else $error("division did not end after 16 clocks");

    go_holds_a: assert property (disable iff (!nrst)
        (divide_go && cnt != MDU_DIV_LAST) |=> divide_go)
        else $error("go dropped before the division ended");

    go_needs_mode_a: assert property (disable iff (!nrst)
        $rose(divide_go) |-> divide_select)
        else $error("go set outside divide mode");

    irq_clears_go_a: assert property (disable iff (!nrst)
        divide_done_irq |-> (!divide_go && $past(divide_go)))
        else $error("interrupt without end of division");

    mul_result_a: assert property (disable iff (!nrst)
        mul_pend |=> ({operand_b_high, operand_b_low}
                      == $past(operand_a_high) * $past(operand_a_low)))
        else $error("product wrong one clock after start");

    single_half_a: assert property (disable iff (!nrst)
        (req.wr && req.addr == MDU_ADDR_A_HIGH && !lo_written
         && !mul_pend && !hi_written) |=> !mul_pend)
        else $error("one operand half started a multiply");

    div_result_a: assert property (disable iff (!nrst)
        (divide_done_irq && chk_divisor != 32'h0000_0000) |->
        ({32'h0, operand_a_high, operand_a_low} * {32'h0, chk_divisor}
         + {32'h0, remainder_high, remainder_low} == {32'h0, chk_dividend}
         && {remainder_high, remainder_low} < chk_divisor))
        else $error("quotient or remainder wrong");

    rem_still_a: assert property (disable iff (!nrst)
        (!divide_go && !(req.wr && req.addr == MDU_ADDR_CTRL))
        |=> $stable({remainder_high, remainder_low}))
        else $error("remainder changed outside division");

    ctrl_read_a: assert property (disable iff (!nrst)
        (req.rd && req.addr == MDU_ADDR_CTRL) |=>
        (rdata[15:8] == 8'h00 && rdata[6:1] == 6'h00
         && rdata[7] == $past(divide_select)
         && rdata[0] == $past(divide_go)))
        else $error("control read shows a wrong bit");

    mode_no_mul_a: assert property (disable iff (!nrst)
        divide_select |=> !mul_pend)
        else $error("multiply started in divide mode");

    mul_once_a: assert property (disable iff (!nrst)
        mul_pend |=> !mul_pend)
        else $error("one pair of writes started two multiplies");

    irq_pulse_a: assert property (disable iff (!nrst)
        divide_done_irq |=> !divide_done_irq)
        else $error("completion interrupt longer than one clock");

    mul_done_c: cover property (disable iff (!nrst) mul_pend ##1 !mul_pend);
    div_done_c: cover property (disable iff (!nrst) $fell(divide_go));
    div_rem_c: cover property (disable iff (!nrst)
        divide_done_irq && remainder_low != 16'h0000);
    div_poke_c: cover property (disable iff (!nrst)
        divide_go && req.wr && req.addr == MDU_ADDR_CTRL);
    lone_half_c: cover property (disable iff (!nrst)
        lo_written && !hi_written && !divide_select);

endmodule // mdu_unit
